//--- logic/audio_serial_tx_clock_enable.sv
// Transmit clocking, frame sync and five-lane enable logic of the serial audio port.
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module audio_serial_tx_clock_enable (
  input wire logic clk_i, // System clock, 10 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Bus write.
  input wire logic [5:0] wb_adr_i, // Bus byte address.
  input wire logic [3:0] wb_sel_i, // Bus byte enables.
  input wire logic [31:0] wb_dat_i, // Bus write data.
  output logic [31:0] wb_dat_o, // Bus read data.
  output logic wb_ack_o, // Bus acknowledge.
  input wire logic tx_bit_clock_pin_i, // Bit clock pin level.
  output logic tx_bit_clock_pin_o, // Bit clock pin drive.
  output logic tx_bit_clock_pin_oe_o, // Bit clock pin enable.
  input wire logic tx_frame_sync_pin_i, // Frame sync pin level.
  output logic tx_frame_sync_pin_o, // Frame sync pin drive.
  output logic tx_frame_sync_pin_oe_o, // Frame sync pin enable.
  input wire logic tx_hf_clock_pin_i, // High-frequency clock pin level.
  output logic tx_hf_clock_pin_o, // High-frequency clock pin drive.
  output logic tx_hf_clock_pin_oe_o, // High-frequency clock pin enable.
  output logic [audio_tx_pkg::NUM_LANES-1:0] ser_lane_pin_o, // Lane data pins 0..4.
  output logic [audio_tx_pkg::NUM_LANES-1:0] ser_lane_pin_oe_o, // Lane data pin enables.
  input wire logic [audio_tx_pkg::NUM_SHARED-1:0] shared_ser_pin_i, // Levels of lane pins 2..4.
  output logic [audio_tx_pkg::NUM_SHARED-1:0] rx_shared_bit_o, // Received bit of pins 2..4.
  output logic [audio_tx_pkg::NUM_SHARED-1:0] rx_shared_valid_o, // Pins 2..4 act as inputs.
  output logic rx_bit_tick_o, // Receive sample strobe in synchronous mode.
  output logic rx_frame_start_o // Receive frame start in synchronous mode.
);
  import audio_tx_pkg::*;

  // All state of the block.
  typedef struct packed {
    logic [23:0] tx_control; // Transmit control register.
    logic [23:0] tx_clock_control; // Transmit clock control register.
    logic [3:0] rx_control_reg; // Receive control register.
    logic [NUM_LANES-1:0][23:0] data; // Transmit data registers.
    logic [NUM_LANES-1:0] full; // Data register holds an unsent word.
    logic [NUM_LANES-1:0][23:0] shift; // Shift registers.
    lane_state_type [NUM_LANES-1:0] lst; // Lane states.
    logic [4:0] bitcnt; // Bit position in the word.
    logic [1:0] slot; // Word slot in the frame.
    logic frame_pend; // External frame start awaits a launch edge.
    logic fs_prev; // Active sync level at the previous capture.
    logic [3:0] div; // Internal bit clock divider.
    logic bclk_int; // Internal bit clock.
    logic bclk_prev; // Previous selected bit clock level.
    logic hf_int; // Internal high-frequency clock.
    logic bclk_s1; // Synchroniser stages.
    logic bclk_s2;
    logic fs_s1;
    logic fs_s2;
    logic hf_s1;
    logic hf_s2;
    logic hf_s3;
    logic [NUM_SHARED-1:0] sh_s1;
    logic [NUM_SHARED-1:0] sh_s2;
    logic fs_gen; // Generated frame sync, active high.
    logic fs_o; // Frame sync pin drive.
    logic [NUM_LANES-1:0] lane_o; // Lane pin drive.
    logic [NUM_LANES-1:0] lane_oe; // Lane pin enable.
    logic [NUM_SHARED-1:0] rx_bit; // Received shared-pin bits.
    logic [NUM_SHARED-1:0] rx_valid; // Shared pins acting as inputs.
    logic rx_tick; // Receive sample strobe.
    logic rx_fs; // Receive frame start.
    logic ack; // Bus acknowledge.
    logic [31:0] dat; // Bus read data.
  } state_type;

  state_type r; // Registered state.
  state_type n; // Next state.
  logic bsel; // Selected bit clock level.
  logic launch; // Launch edge of the bit clock.
  logic capture; // Capture edge of the bit clock.
  logic launch_fall; // Launch on the falling edge.
  logic fstart; // Frame starts at this launch.
  logic wbound; // Word boundary at this launch.
  logic req; // New bus request.
  logic fs_act; // Sampled sync at its active level.
  logic [31:0] mw; // Register word after a byte-lane merge.

  // Byte-lane merge of a write into a register word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Lane index of a data register address, or 7 when the address is not one.
  function automatic logic [2:0] data_lane(input logic [5:0] adr);
    logic [2:0] idx;
    idx = 3'h7;
    for (int l = 0; l < NUM_LANES; l++) begin
      if (adr == OFS_TX_DATA0 + 6'(4 * l)) begin
        idx = 3'(l);
      end
    end
    return idx;
  endfunction

  // Next-state logic: bus slave, clocks, frame timing and lanes.
  always_comb begin
    n = r;
    mw = 32'h00000000;
    req = wb_cyc_i && wb_stb_i && !r.ack;
    // Synchronisers; only the second stage and later are read.
    n.bclk_s1 = tx_bit_clock_pin_i;
    n.bclk_s2 = r.bclk_s1;
    n.fs_s1 = tx_frame_sync_pin_i;
    n.fs_s2 = r.fs_s1;
    n.hf_s1 = tx_hf_clock_pin_i;
    n.hf_s2 = r.hf_s1;
    n.hf_s3 = r.hf_s2;
    n.sh_s1 = shared_ser_pin_i;
    n.sh_s2 = r.sh_s1;
    // High-frequency clock runs at half the system clock.
    n.hf_int = !r.hf_int;
    // Internal bit clock counts system clocks or external high-frequency edges.
    if (r.tx_clock_control[HF_DIR_BIT] || (r.hf_s2 && !r.hf_s3)) begin
      if (r.div == BITCLK_HALF_CYC - 4'h1) begin
        n.div = 4'h0;
        n.bclk_int = !r.bclk_int;
      end else begin
        n.div = r.div + 4'h1;
      end
    end
    // Bit clock source: internal when the direction bit is set, the pin otherwise.
    bsel = r.tx_clock_control[BITCLK_DIR_BIT] ? r.bclk_int : r.bclk_s2;
    n.bclk_prev = bsel;
    launch_fall = r.tx_clock_control[EDGE_SEL_BIT] ^ r.tx_clock_control[HF_POL_BIT];
    launch = launch_fall ? (!bsel && r.bclk_prev) : (bsel && !r.bclk_prev);
    capture = launch_fall ? (bsel && !r.bclk_prev) : (!bsel && r.bclk_prev);
    // Frame start: end of the last slot when generated, a detected edge otherwise.
    if (r.tx_clock_control[FSYNC_DIR_BIT]) begin
      fstart = (r.bitcnt == LAST_BIT) && (!r.tx_control[NET_MODE_BIT] || r.slot == NET_LAST_SLOT);
    end else begin
      fstart = r.frame_pend;
    end
    wbound = launch && (fstart || r.bitcnt == LAST_BIT);
    fs_act = r.fs_s2 ^ r.tx_clock_control[FSYNC_POL_BIT];
    n.rx_tick = r.rx_control_reg[SYNC_MODE_BIT] && capture;
    n.rx_fs = 1'b0;
    // Capture edge: detect external frame start and sample shared pins.
    if (capture) begin
      n.fs_prev = fs_act;
      if (!r.tx_clock_control[FSYNC_DIR_BIT] && fs_act && !r.fs_prev) begin
        n.frame_pend = 1'b1;
      end
      for (int k = 0; k < NUM_SHARED; k++) begin
        n.rx_bit[k] = r.rx_valid[k] && r.sh_s2[k];
      end
    end
    // Shared pin acts as receive input only with its lane off and receiver on.
    for (int k = 0; k < NUM_SHARED; k++) begin
      n.rx_valid[k] = !r.tx_control[k + 2] && r.rx_control_reg[NUM_SHARED - k];
    end
    // Launch edge: bit and slot counting, sync generation and lane shifting.
    if (launch) begin
      n.frame_pend = 1'b0;
      n.fs_gen = r.tx_clock_control[FSYNC_DIR_BIT] && fstart;
      n.fs_o = n.fs_gen ^ r.tx_clock_control[FSYNC_POL_BIT];
      n.rx_fs = r.rx_control_reg[SYNC_MODE_BIT] && fstart;
      if (fstart) begin
        n.bitcnt = 5'h00;
        n.slot = 2'h0;
      end else if (r.bitcnt == LAST_BIT) begin
        n.bitcnt = 5'h00;
        n.slot = r.slot + 2'h1;
      end else begin
        n.bitcnt = r.bitcnt + 5'h01;
      end
      for (int l = 0; l < NUM_LANES; l++) begin
        if (wbound) begin
          // Enable changes act only here, so words are never cut short.
          if (r.tx_control[l] && (fstart || (r.tx_control[NET_MODE_BIT] && r.lst[l] != LANE_BLOCKED))) begin
            n.lst[l] = LANE_SHIFT;
            n.lane_o[l] = r.data[l][23];
            n.shift[l] = {r.data[l][22:0], 1'b0};
            n.full[l] = 1'b0;
          end else if (!r.tx_control[l] && r.tx_control[NET_MODE_BIT] && !fstart) begin
            n.lst[l] = LANE_BLOCKED;
          end else if (r.lst[l] != LANE_BLOCKED || fstart) begin
            n.lst[l] = LANE_IDLE;
          end
        end else if (r.lst[l] == LANE_SHIFT) begin
          n.lane_o[l] = r.shift[l][23];
          n.shift[l] = {r.shift[l][22:0], 1'b0};
        end
      end
    end
    for (int l = 0; l < NUM_LANES; l++) begin
      n.lane_oe[l] = (n.lst[l] == LANE_SHIFT);
    end
    // Bus slave: one-cycle answer, write takes effect with the answer.
    n.ack = req;
    n.dat = 32'h00000000;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        OFS_TX_CONTROL: begin
          mw = merge({8'h00, r.tx_control}, wb_dat_i, wb_sel_i);
          n.tx_control = mw[23:0] & TX_CONTROL_WMASK;
        end
        OFS_TX_CLOCK_CONTROL: begin
          mw = merge({8'h00, r.tx_clock_control}, wb_dat_i, wb_sel_i);
          n.tx_clock_control = mw[23:0];
        end
        OFS_RX_CONTROL: begin
          mw = merge({28'h0000000, r.rx_control_reg}, wb_dat_i, wb_sel_i);
          n.rx_control_reg = mw[3:0];
        end
        OFS_SOFT_RESET: begin
          if (wb_sel_i[0] && wb_dat_i[SOFT_RESET_BIT]) begin
            n.tx_control = CONTROL_RESET;
            n.tx_clock_control = CONTROL_RESET;
          end
        end
        default: begin
          // Data registers accept writes whether or not the lane is enabled.
          if (data_lane(wb_adr_i) != 3'h7) begin
            mw = merge({8'h00, r.data[data_lane(wb_adr_i)]}, wb_dat_i, wb_sel_i);
            n.data[data_lane(wb_adr_i)] = mw[23:0];
            n.full[data_lane(wb_adr_i)] = 1'b1;
          end
        end
      endcase
    end else if (req) begin
      case (wb_adr_i)
        OFS_TX_CONTROL: begin
          n.dat = {8'h00, r.tx_control};
        end
        OFS_TX_CLOCK_CONTROL: begin
          n.dat = {8'h00, r.tx_clock_control};
        end
        OFS_RX_CONTROL: begin
          n.dat = {28'h0000000, r.rx_control_reg};
        end
        OFS_STATUS: begin
          n.dat = {22'h000000, r.lane_oe, ~r.full};
        end
        default: begin
          if (data_lane(wb_adr_i) != 3'h7) begin
            n.dat = {8'h00, r.data[data_lane(wb_adr_i)]};
          end
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs come straight from state flip-flops.
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign tx_bit_clock_pin_o = r.bclk_int;
  assign tx_bit_clock_pin_oe_o = r.tx_clock_control[BITCLK_DIR_BIT];
  assign tx_frame_sync_pin_o = r.fs_o;
  assign tx_frame_sync_pin_oe_o = r.tx_clock_control[FSYNC_DIR_BIT];
  assign tx_hf_clock_pin_o = r.hf_int;
  assign tx_hf_clock_pin_oe_o = r.tx_clock_control[HF_DIR_BIT];
  assign ser_lane_pin_o = r.lane_o;
  assign ser_lane_pin_oe_o = r.lane_oe;
  assign rx_shared_bit_o = r.rx_bit;
  assign rx_shared_valid_o = r.rx_valid;
  assign rx_bit_tick_o = r.rx_tick;
  assign rx_frame_start_o = r.rx_fs;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Soft reset request; the property then waits for the acknowledge.
  sequence soft_reset_s;
    req && wb_we_i && wb_adr_i == OFS_SOFT_RESET && wb_sel_i[0] && wb_dat_i[0];
  endsequence

  // Generated frame start at a launch edge.
  sequence gen_start_s;
    launch && fstart && r.tx_clock_control[FSYNC_DIR_BIT];
  endsequence

  edge_rise_a: assert property (launch && !launch_fall |-> bsel && !r.bclk_prev)
    else $error("launch not on rising edge");
  edge_fall_a: assert property (launch && launch_fall |-> !bsel && r.bclk_prev)
    else $error("launch not on falling edge");
  hf_swap_a: assert property (r.tx_clock_control[HF_POL_BIT] && !r.tx_clock_control[EDGE_SEL_BIT] && capture |-> bsel)
    else $error("capture edge not swapped");
  sync_level_a: assert property (gen_start_s |=> tx_frame_sync_pin_o == !r.tx_clock_control[FSYNC_POL_BIT])
    else $error("frame start level wrong");
  clk_runs_a: assert property ((r.tx_clock_control[BITCLK_DIR_BIT] && r.tx_clock_control[HF_DIR_BIT] && $stable(r.bclk_int))[*4] |=> $changed(r.bclk_int) || !(r.tx_clock_control[BITCLK_DIR_BIT] && r.tx_clock_control[HF_DIR_BIT]))
    else $error("internal bit clock stalled");
  ext_clock_a: assert property (!r.tx_clock_control[BITCLK_DIR_BIT] && launch && !launch_fall |-> r.bclk_s2)
    else $error("external clock not used");
  soft_clear_a: assert property (soft_reset_s ##1 wb_ack_o |-> r.tx_control == 24'h000000 && r.tx_clock_control == 24'h000000)
    else $error("soft reset left control bits");
  lane_start_a: assert property (launch && fstart && r.tx_control[0] |=> ser_lane_pin_oe_o[0] && !r.full[0])
    else $error("lane did not start");
  word_end_a: assert property ($fell(ser_lane_pin_oe_o[1]) |-> $past(wbound))
    else $error("lane stopped mid word");
  blocked_a: assert property (r.lst[0] == LANE_BLOCKED && !(launch && fstart) |=> !ser_lane_pin_oe_o[0])
    else $error("blocked lane drove pin");
  share_in_a: assert property (rx_shared_valid_o[0] |-> !ser_lane_pin_oe_o[2] || $past(r.lst[2] == LANE_SHIFT))
    else $error("shared pin driven while receiving");
  rx_sync_a: assert property (rx_frame_start_o || rx_bit_tick_o |-> $past(r.rx_control_reg[SYNC_MODE_BIT]))
    else $error("receive timing without sync mode");
  dirs_a: assert property ($changed(r.tx_clock_control) |-> tx_frame_sync_pin_oe_o == r.tx_clock_control[FSYNC_DIR_BIT] && tx_hf_clock_pin_oe_o == r.tx_clock_control[HF_DIR_BIT])
    else $error("pin direction mismatch");
endmodule // audio_serial_tx_clock_enable
`default_nettype wire

//--- shared/audio_tx_pkg.sv
// Constants, register map and types of the serial audio transmit clock and lane-enable block.
// Operation
// - Edge select clear: launch rising, sample falling.
// - Edge select set: launch falling, sample rising.
// - Sync polarity: clear high start, set low.
// - High-frequency polarity also swaps launch/capture edges.
// - Bit-clock dir set: internal clock drives pin.
// - Bit-clock dir clear: external clock from pin.
// - Synchronous mode also clocks the receive side.
// - Frame-sync dir: clear input, set drives sync.
// - High-frequency dir: clear input, set output.
// - Both resets clear the transmit control register.
// - Lane starts on frame sync when enabled; in network mode the code also starts an unblocked lane at any word boundary.
// - Disable finishes current word, then output floats.
// - Shared pin receives or floats by enables.
// - Network re-enable waits for the next frame.
// - Both resets clear the clock control register.
// - Sync pin serves receivers only in synchronous mode.
package audio_tx_pkg;
  // Wishbone byte offsets of the register words.
  localparam logic [5:0] OFS_TX_CONTROL = 6'h00;
  localparam logic [5:0] OFS_TX_CLOCK_CONTROL = 6'h04;
  localparam logic [5:0] OFS_RX_CONTROL = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0c;
  localparam logic [5:0] OFS_SOFT_RESET = 6'h10;
  localparam logic [5:0] OFS_TX_DATA0 = 6'h14;
  // Sizes.
  localparam int NUM_LANES = 5;
  localparam int NUM_SHARED = 3;
  localparam int WORD_BITS = 24;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [1:0] NET_LAST_SLOT = 2'h1;
  // Transmit control field positions.
  localparam int NET_MODE_BIT = 8;
  localparam logic [23:0] TX_CONTROL_WMASK = 24'hfbffff;
  localparam logic [23:0] CONTROL_RESET = 24'h000000;
  // Clock control field positions.
  localparam int EDGE_SEL_BIT = 18;
  localparam int FSYNC_POL_BIT = 19;
  localparam int HF_POL_BIT = 20;
  localparam int BITCLK_DIR_BIT = 21;
  localparam int FSYNC_DIR_BIT = 22;
  localparam int HF_DIR_BIT = 23;
  // Receive control field positions: mode at 0, receive lane enables 1..3.
  localparam int SYNC_MODE_BIT = 0;
  localparam int SOFT_RESET_BIT = 0;
  // Internal bit clock timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int BITCLK_HALF_NS = 500;
  localparam logic [3:0] BITCLK_HALF_CYC = 4'((BITCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Lane states, Gray coded along idle, shifting, blocked.
  typedef enum logic [1:0] {
    LANE_IDLE = 2'b00,
    LANE_SHIFT = 2'b01,
    LANE_BLOCKED = 2'b11
  } lane_state_type;
endpackage

//--- verification/audio_codec_model.sv
// Behavioural model of the external codec on the transmit pins.
`timescale 1ns/100ps
`default_nettype none
module audio_codec_model (
  input wire logic clk_i, // System clock.
  input wire logic run_i, // Codec supplies the bit clock while high.
  output logic ext_bitclk_o, // Bit clock from the codec.
  output logic ext_fsync_o, // Frame sync from the codec, active high.
  output logic ext_hfclk_o, // High-frequency clock from the codec.
  output logic [2:0] ext_shared_o // Levels the codec puts on shared pins.
);
  logic [3:0] div_r = 4'h0; // Clocks per bit-clock half period.
  logic [5:0] bit_r = 6'h00; // Bit position within the codec frame.
  initial begin
    ext_bitclk_o = 1'b0;
    ext_fsync_o = 1'b0;
    ext_hfclk_o = 1'b0;
  end
  // Codec bit clock stands still between runs; a one-bit sync leaves on the rising edge every 24 bits.
  always @(posedge clk_i) begin
    ext_hfclk_o <= ~ext_hfclk_o;
    if (!run_i) begin
      div_r <= 4'h0;
      ext_bitclk_o <= 1'b0;
      ext_fsync_o <= 1'b0;
    end else if (div_r == 4'h6) begin
      div_r <= 4'h0;
      ext_bitclk_o <= ~ext_bitclk_o;
      if (!ext_bitclk_o) begin
        bit_r <= (bit_r == 6'h17) ? 6'h00 : bit_r + 6'h01;
        ext_fsync_o <= (bit_r == 6'h17);
      end
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  // Fixed receive pattern on the shared pins.
  assign ext_shared_o = 3'h5;
endmodule // audio_codec_model
`default_nettype wire

//--- verification/tb_audio_serial_tx_clock_enable.sv
// Self-checking bench of the serial audio transmit clock and lane-enable block.
`timescale 1ns/100ps
`default_nettype none
module tb_audio_serial_tx_clock_enable;
  import audio_tx_pkg::*;
  logic clk_i = 1'b0; // 10 MHz clock.
  logic rst_i = 1'b1; // Reset, held at start.
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0; // Bus request and codec run.
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, bclk_o, bclk_oe, fs_o, fs_oe, hf_o, hf_oe, ext_bclk, ext_fs, ext_hf, tick, rx_fs;
  logic [4:0] lane_o, lane_oe;
  logic [2:0] ext_sh, rx_bit, rx_valid;
  int miscompares = 0, n_tests = 0, cycles = 0;
  logic [23:0] cfgs [5] = '{24'he00000, 24'he40000, 24'hf80000, 24'hfc0000, 24'h000000};
  // Pin levels resolved from both parties' drives.
  wire logic bclk = bclk_oe ? bclk_o : ext_bclk;
  wire logic fs = fs_oe ? fs_o : ext_fs;
  wire logic hf = hf_oe ? hf_o : ext_hf;
  wire logic [2:0] sh = (lane_oe[4:2] & lane_o[4:2]) | (~lane_oe[4:2] & ext_sh);
  audio_serial_tx_clock_enable dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_bit_clock_pin_i(bclk), .tx_bit_clock_pin_o(bclk_o), .tx_bit_clock_pin_oe_o(bclk_oe),
    .tx_frame_sync_pin_i(fs), .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe_o(fs_oe),
    .tx_hf_clock_pin_i(hf), .tx_hf_clock_pin_o(hf_o), .tx_hf_clock_pin_oe_o(hf_oe),
    .ser_lane_pin_o(lane_o), .ser_lane_pin_oe_o(lane_oe), .shared_ser_pin_i(sh),
    .rx_shared_bit_o(rx_bit), .rx_shared_valid_o(rx_valid), .rx_bit_tick_o(tick), .rx_frame_start_o(rx_fs));
  audio_codec_model codec (.clk_i(clk_i), .run_i(run), .ext_bitclk_o(ext_bclk), .ext_fsync_o(ext_fs),
    .ext_hfclk_o(ext_hf), .ext_shared_o(ext_sh));
  // Clock generator.
  always #50 clk_i = ~clk_i;
  // Timeout guard against a hung handshake or a lane that never starts.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("BAD at %0t: timeout", $time);
      print_verdict();
    end
  end
  // Compares one value and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One classic Wishbone cycle; waits for the acknowledge, then releases for a cycle.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp, what);
  endtask
  // Reset values, read-back, unmapped place and soft reset.
  task automatic t_regs;
    rdchk(OFS_TX_CONTROL, 32'h0, "control after reset");
    rdchk(OFS_TX_CLOCK_CONTROL, 32'h0, "clock control after reset");
    rdchk(6'h3c, 32'h0, "unmapped read");
    wr(OFS_TX_CONTROL, 32'hffffe0);
    wr(OFS_TX_CLOCK_CONTROL, 32'hffffff);
    rdchk(OFS_TX_CONTROL, 32'hfbffe0, "control read-back");
    rdchk(OFS_TX_CLOCK_CONTROL, 32'hffffff, "clock control read-back");
    wr(OFS_SOFT_RESET, 32'h1);
    rdchk(OFS_TX_CONTROL, 32'h0, "control after soft reset");
    rdchk(OFS_TX_CLOCK_CONTROL, 32'h0, "clock control after soft reset");
    $display("test regs done");
  endtask
  // One word on lane l under clock setting cfg; enable dropped in mid-word.
  task automatic t_lane(input int l, input logic [23:0] cfg);
    logic [23:0] d, got;
    logic cap;
    int b;
    d = 24'hb45a0f ^ {21'h0, 3'(l)};
    cap = cfg[18] ^ cfg[20];
    wr(OFS_TX_CLOCK_CONTROL, {8'h0, cfg});
    check({29'h0, hf_oe, fs_oe, bclk_oe}, {29'h0, cfg[23:21]}, "pin directions");
    run <= ~cfg[21];
    wr(OFS_TX_DATA0 + 6'(4 * l), {8'h0, d});
    wr(OFS_TX_CONTROL, 32'h1 << l);
    while (lane_oe[l] !== 1'b1) @(posedge clk_i);
    for (b = 0; b < 24; b++) begin
      if (cap) @(posedge bclk); else @(negedge bclk);
      if (b == 0 && cfg[22]) check({31'h0, fs}, {31'h0, ~cfg[19]}, "sync at frame start");
      got[23 - b] = lane_o[l];
      if (b == 2) wr(OFS_TX_CONTROL, 32'h0);
    end
    check({8'h0, got}, {8'h0, d}, "lane word");
    if (cap) @(posedge bclk); else @(negedge bclk);
    check({31'h0, lane_oe[l]}, 32'h0, "lane released");
    run <= 1'b0;
    $display("test lane %0d done", l);
  endtask
  // Shared pins as receive inputs, and receive clocking by mode.
  task automatic t_shared;
    int k, c, n, fr, h;
    wr(OFS_TX_CLOCK_CONTROL, 32'he00000);
    for (k = 0; k < 3; k++) begin
      wr(OFS_RX_CONTROL, {28'h0, 4'h1 << (3 - k)} | {31'h0, ~k[0]});
      n = 0;
      fr = 0;
      h = 0;
      for (c = 0; c < 260; c++) begin
        @(posedge clk_i);
        if (tick === 1'b1) n++;
        if (rx_fs === 1'b1) fr++;
        if (hf_o === 1'b1) h++;
      end
      check({31'h0, fr > 0}, {31'h0, ~k[0]}, "receive frame start by mode");
      check(h, 130, "high-frequency clock output");
      check({29'h0, rx_valid}, 32'h1 << k, "shared pin as input");
      check({31'h0, n > 0}, {31'h0, ~k[0]}, "receive ticks by mode");
      check({31'h0, rx_bit[k]}, {31'h0, ext_sh[k]}, "shared pin sample");
    end
    wr(OFS_RX_CONTROL, 32'h0);
    @(posedge clk_i);
    check({26'h0, rx_valid, lane_oe[4:2]}, 32'h0, "shared pins float");
    $display("test shared done");
  endtask
  // Network mode: a mid-frame reload, then clear and re-set keeps the lane off until the next frame.
  task automatic t_net;
    logic [3:0] seen;
    int b;
    seen = 4'h0;
    wr(OFS_TX_CLOCK_CONTROL, 32'he00000);
    wr(OFS_TX_DATA0, 32'h3c96a5);
    wr(OFS_TX_CONTROL, 32'h1);
    while (lane_oe[0] !== 1'b1) @(posedge clk_i);
    wr(OFS_TX_CONTROL, 32'h101);
    for (b = 0; b < 97; b++) begin
      @(negedge bclk);
      if (b == 25) seen[3] = lane_oe[0];
      if (b == 73) seen[2] = lane_oe[0];
      if (b == 85) seen[1] = lane_oe[0];
      if (b == 97 - 1) seen[0] = lane_oe[0];
      if (b == 49) rdchk(OFS_STATUS, 32'h3f, "data empty before disable");
      if (b == 50) wr(OFS_TX_CONTROL, 32'h100);
      if (b == 77) wr(OFS_TX_CONTROL, 32'h101);
    end
    check({28'h0, seen}, 32'h9, "network reload and block");
    wr(OFS_TX_CONTROL, 32'h0);
    $display("test network done");
  endtask
  // Final counts and verdict.
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    int i;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    for (i = 0; i < 5; i++) t_lane(i, cfgs[i]);
    t_shared();
    t_net();
    print_verdict();
  end
endmodule // tb_audio_serial_tx_clock_enable
`default_nettype wire
